// file: hw/tx_dma_channel_context_ram.v
`timescale 1ns/1ps
`include "tx_dma_channel_context_ram_defines.vh"

module tx_dma_channel_context_ram (
	input wire core_clk,
	input wire rst,
	input wire [11:0] regAddr,
	input wire regWrEn,
	input wire regRdEn,
	input wire [15:0] regWrData,
	output reg [15:0] regRdData,
	output reg regRdValid,
	input wire dmaRdEn,
	input wire [7:0] dmaRdChan,
	input wire [2:0] dmaRdDword,
	output reg [31:0] dmaRdData,
	output reg dmaRdValid,
	output reg ctxChanActive,
	output reg [12:0] ctxByteCount,
	output reg ctxNextPtrValid,
	output reg [3:0] ctxOkStatusMask,
	output reg ctxPriorityBusy,
	input wire dmaWrEn,
	input wire [7:0] dmaWrChan,
	input wire [2:0] dmaWrDword,
	input wire [1:0] dmaWrHalf,
	input wire [31:0] dmaWrData,
	input wire dmaErrEn,
	input wire [7:0] dmaErrChan,
	input wire dmaRestartEn,
	input wire [7:0] dmaRestartChan
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Flat index is channel times six plus dword; two shifts and an add
	// stand in for a multiplier.
	function [10:0] ctxIndex;
		input [7:0] chan;
		input [2:0] dword;
		begin
			ctxIndex = ({3'h0, chan} << 2) + ({3'h0, chan} << 1) + {8'h00, dword};
		end
	endfunction

	// Bits outside the mask have no meaning and always read zero, so the
	// engine and the host see the same value for every word.
	function [31:0] keepMask;
		input [2:0] dword;
		begin
			case (dword)
				3'd1: keepMask = `D1_KEEP_MASK;
				3'd4: keepMask = `D4_KEEP_MASK;
				default: keepMask = 32'hffffffff;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Storage. Each dword is split into two halves so the host can touch one
	// half without a read-modify-write. The enable bit lives in flops so that
	// error and restart events can change it without a memory cycle.
	// Context words are not reset, so a word must be written before it is
	// relied on; only the enable bits come out of reset at a known value.

	reg [15:0] ctxLo [0:`CTX_ENTRIES-1];
	reg [15:0] ctxHi [0:`CTX_ENTRIES-1];
	reg [255:0] activeVec_r;

	////////////////////////////////////////////////////////////////////////////
	// Select and data registers, and the sequencer that moves one 16-bit
	// word between the data register and the store.

	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_CAPT = 2'd2;

	reg [1:0] state_r;
	reg [7:0] selChan_r;
	reg [3:0] selWord_r;
	reg selDir_r;
	reg busy_r;
	reg [15:0] data_r;
	reg [15:0] hostLo_r;
	reg [15:0] hostHi_r;
	reg hostHalf_r;
	reg hostCodeOk_r;

	wire selWrite;
	wire dataWrite;
	wire memBusyDma;
	wire [10:0] hostIdx;
	wire hostCodeOk;
	wire hostWrOk;
	wire hostIssue;

	assign selWrite = regWrEn && (regAddr == `OFS_INDIRECT_SELECT);
	assign dataWrite = regWrEn && (regAddr == `OFS_INDIRECT_DATA);
	assign memBusyDma = dmaRdEn || dmaWrEn;
	// Word code 2n or 2n+1 lands in dword n.
	assign hostIdx = ctxIndex(selChan_r, selWord_r[3:1]);
	assign hostCodeOk = (selWord_r <= `WORD_LAST);
	assign hostWrOk = (selWord_r == `WORD_HOST_WRITABLE);
	// The engine always wins the memory; host accesses wait for a free cycle.
	// There is no fairness counter, so an engine that uses the memory every
	// cycle holds a host access off for as long as it keeps doing so.
	assign hostIssue = (state_r == ST_WAIT) && !memBusyDma;

	// A select write latches the request and raises busy.
	// The first later edge with the memory free issues the access.
	// A write completes on that edge; a read goes on to a capture cycle.
	// The capture moves the addressed half into the data register and
	// drops busy, so a read shows busy for two cycles at least, a write
	// for one, and every cycle of engine traffic adds one more.

	always @(posedge core_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			selChan_r <= 8'h00;
			selWord_r <= 4'h0;
			selDir_r <= 1'b0;
			busy_r <= 1'b0;
			data_r <= `DATA_RESET;
		end else begin
			case (state_r)
				ST_IDLE: begin
					// Select writes while busy are ignored, so state cannot tear.
					if (selWrite) begin
						selChan_r <= regWrData[`SEL_CHAN_MSB:`SEL_CHAN_LSB];
						selWord_r <= regWrData[`SEL_WORD_MSB:`SEL_WORD_LSB];
						selDir_r <= regWrData[`SEL_DIR_BIT];
						busy_r <= 1'b1;
						state_r <= ST_WAIT;
					end else if (dataWrite) begin
						data_r <= regWrData;
					end
				end
				ST_WAIT: begin
					// Stay here until the engine leaves a memory cycle free.
					if (hostIssue) begin
						if (selDir_r) begin
							state_r <= ST_CAPT;
						end else begin
							busy_r <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
				end
				ST_CAPT: begin
					// Codes above 1011 select nothing and return zero.
					if (!hostCodeOk_r) begin
						data_r <= 16'h0000;
					end else if (hostHalf_r) begin
						data_r <= hostHi_r;
					end else begin
						// Dword 1 bit 0 already came from the enable flops at issue.
						data_r <= hostLo_r;
					end
					busy_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: begin
					// An unused state code recovers to idle and drops busy.
					busy_r <= 1'b0;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Register reads answer one cycle after the strobe and return zero at
	// all other times, so a stale word never lingers on the read bus.
	// The select readback is rebuilt from its fields; bits 13 and 12 have
	// no storage and read zero.
	always @(posedge core_clk) begin
		if (rst) begin
			regRdData <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (!regRdEn) begin
				regRdData <= 16'h0000;
			end else if (regAddr == `OFS_INDIRECT_SELECT) begin
				regRdData <= {busy_r, selDir_r, 2'b00, selWord_r, selChan_r};
			end else if (regAddr == `OFS_INDIRECT_DATA) begin
				regRdData <= data_r;
			end else begin
				regRdData <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory read port shared by the engine and the host sequencer.
	// Only dword 1 takes bit 0 from the enable flops; every other dword
	// keeps its own bit 0 in memory, so the substitution is gated by the
	// dword number.

	wire [10:0] dmaRdIdx;
	wire [15:0] dmaLoRaw;
	wire [15:0] dmaLoView;
	wire [31:0] dmaRdMasked;
	wire [31:0] d1View;
	wire [31:0] hostKeep;
	wire [15:0] hostLoRaw;
	wire [15:0] hostLoView;
	wire [15:0] hostHiView;

	assign dmaRdIdx = ctxIndex(dmaRdChan, dmaRdDword);
	assign dmaLoRaw = ctxLo[dmaRdIdx];
	assign dmaLoView = (dmaRdDword == 3'd1) ?
		{dmaLoRaw[15:1], activeVec_r[dmaRdChan]} : dmaLoRaw;
	assign dmaRdMasked = {ctxHi[dmaRdIdx], dmaLoView};
	assign d1View = dmaRdMasked & keepMask(dmaRdDword);
	// The host view uses the same gating and masks as the engine view.
	assign hostKeep = keepMask(selWord_r[3:1]);
	assign hostLoRaw = ctxLo[hostIdx];
	assign hostLoView = (selWord_r[3:1] == 3'd1) ?
		{hostLoRaw[15:1], activeVec_r[selChan_r]} : hostLoRaw;
	assign hostHiView = ctxHi[hostIdx] & hostKeep[31:16];

	always @(posedge core_clk) begin
		if (rst) begin
			dmaRdData <= 32'h00000000;
			dmaRdValid <= 1'b0;
			ctxChanActive <= 1'b0;
			ctxByteCount <= 13'h0000;
			ctxNextPtrValid <= 1'b0;
			ctxOkStatusMask <= `OK_STATUS_PER_PACKET;
			ctxPriorityBusy <= 1'b0;
			hostLo_r <= 16'h0000;
			hostHi_r <= 16'h0000;
			hostHalf_r <= 1'b0;
			hostCodeOk_r <= 1'b0;
		end else begin
			dmaRdValid <= dmaRdEn;
			if (dmaRdEn) begin
				dmaRdData <= d1View;
				// The dword 1 decodes follow the engine's last read of that
				// dword, so the engine acts on the setup it fetched and not on
				// a later host write. Per-buffer reporting opens statuses 001
				// to 011 besides 000.
				if (dmaRdDword == 3'd1) begin
					ctxChanActive <= d1View[`D1_ACTIVE_BIT];
					ctxByteCount <= d1View[`D1_COUNT_MSB:`D1_COUNT_LSB];
					// Next pointer is meaningful mid-frame, or at frame end if chained.
					ctxNextPtrValid <= !d1View[`D1_EOF_BIT] || d1View[`D1_CV_BIT];
					ctxPriorityBusy <= d1View[`D1_PRIORITY_BIT];
					if (d1View[`D1_PER_BUFFER_BIT]) begin
						ctxOkStatusMask <= `OK_STATUS_PER_BUFFER;
					end else begin
						ctxOkStatusMask <= `OK_STATUS_PER_PACKET;
					end
				end
			end else if (hostIssue) begin
				hostLo_r <= hostLoView & hostKeep[15:0];
				hostHi_r <= hostHiView;
				hostHalf_r <= selWord_r[0];
				hostCodeOk_r <= hostCodeOk;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory write port. Engine writes carry a half enable; the host writes
	// only the low half of dword 1.
	// Host data is masked like engine data, so an unused bit written by the
	// host never reaches storage and reads back as zero.

	wire [10:0] dmaWrIdx;
	wire [31:0] dmaWrKept;
	wire hostWrite;

	assign dmaWrIdx = ctxIndex(dmaWrChan, dmaWrDword);
	assign dmaWrKept = dmaWrData & keepMask(dmaWrDword);
	assign hostWrite = hostIssue && !selDir_r && hostWrOk;

	always @(posedge core_clk) begin
		if (dmaWrEn && dmaWrHalf[0]) begin
			ctxLo[dmaWrIdx] <= dmaWrKept[15:0];
		end else if (hostWrite) begin
			ctxLo[hostIdx] <= data_r & hostKeep[15:0];
		end
		if (dmaWrEn && dmaWrHalf[1]) begin
			ctxHi[dmaWrIdx] <= dmaWrKept[31:16];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel enable bits. Hardware events take priority over plain writes,
	// and a restart outranks an error on the same channel so a restart is
	// never lost.
	// Each bit has its own priority chain inside the loop, so events on
	// different channels in one cycle never block one another; the cost is
	// one channel compare per event source and bit.
	// An engine write of dword 1 low carries bit 0 into the flops as well.

	integer ch;
	always @(posedge core_clk) begin
		if (rst) begin
			activeVec_r <= 256'h0;
		end else begin
			for (ch = 0; ch < `CTX_CHANNELS; ch = ch + 1) begin
				if (dmaRestartEn && (dmaRestartChan == ch[7:0])) begin
					activeVec_r[ch] <= 1'b1;
				end else if (dmaErrEn && (dmaErrChan == ch[7:0])) begin
					activeVec_r[ch] <= 1'b0;
				end else if (dmaWrEn && dmaWrHalf[0] && (dmaWrDword == 3'd1)
						&& (dmaWrChan == ch[7:0])) begin
					activeVec_r[ch] <= dmaWrData[`D1_ACTIVE_BIT];
				end else if (hostWrite && (selChan_r == ch[7:0])) begin
					activeVec_r[ch] <= data_r[`D1_ACTIVE_BIT];
				end
			end
		end
	end

endmodule

// file: include/tx_dma_channel_context_ram_defines.vh
`ifndef TX_DMA_CHANNEL_CONTEXT_RAM_DEFINES_VH
`define TX_DMA_CHANNEL_CONTEXT_RAM_DEFINES_VH

// Context store geometry.
`define CTX_CHANNELS 256
`define CTX_DWORDS_PER_CHAN 6
`define CTX_ENTRIES 1536
`define CTX_INDEX_W 11

// Host register offsets.
`define OFS_INDIRECT_SELECT 12'h870
`define OFS_INDIRECT_DATA 12'h874

// Indirect select register fields and reset value.
`define SEL_CHAN_LSB 0
`define SEL_CHAN_MSB 7
`define SEL_WORD_LSB 8
`define SEL_WORD_MSB 11
`define SEL_DIR_BIT 14
`define SEL_BUSY_BIT 15
`define SEL_RESET 16'h0000
`define DATA_RESET 16'h0000

// Word codes.
`define WORD_HOST_WRITABLE 4'h2
`define WORD_LAST 4'hb

// Dword 1 field positions.
`define D1_ACTIVE_BIT 0
`define D1_PER_BUFFER_BIT 1
`define D1_COUNT_LSB 3
`define D1_COUNT_MSB 15
`define D1_CV_BIT 16
`define D1_EOF_BIT 17
`define D1_STD_LSB 18
`define D1_STD_MSB 19
`define D1_PRI_LSB 20
`define D1_PRI_MSB 21
`define D1_PRIORITY_BIT 22

// Bits the store keeps; unused bits are dropped and read as zero.
`define D1_KEEP_MASK 32'h007ffffb
`define D4_KEEP_MASK 32'h0000ffff

// Allowed non-error done status sets, bit n set means status n allowed.
`define OK_STATUS_PER_PACKET 4'h1
`define OK_STATUS_PER_BUFFER 4'hf

`endif

// file: tb/tx_dma_channel_context_ram_properties.sv
`timescale 1ns/1ps
module tx_ctx_properties (
	input wire core_clk,
	input wire rst,
	input wire [11:0] regAddr,
	input wire regRdEn,
	input wire [15:0] regRdData,
	input wire regRdValid,
	input wire dmaRdEn,
	input wire dmaRdValid,
	input wire [3:0] ctxOkStatusMask
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	rd_answer_a: assert property (regRdEn |=> regRdValid)
		else $error("host read got no answer");
	rd_cause_a: assert property (regRdValid |-> $past(regRdEn))
		else $error("host answer without request");
	rd_idle_a: assert property (!regRdValid |-> regRdData == 16'h0000)
		else $error("read data not zero outside answer");
	sel_spare_a: assert property (regRdEn && regAddr == 12'h870 |=> regRdData[13:12] == 2'b00)
		else $error("spare select bits not zero");
	unmapped_zero_a: assert property (regRdEn && regAddr != 12'h870 && regAddr != 12'h874
		|=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	dma_answer_a: assert property (dmaRdEn |=> dmaRdValid)
		else $error("engine read got no answer");
	dma_cause_a: assert property (!dmaRdEn |=> !dmaRdValid)
		else $error("engine answer without request");
	mask_code_a: assert property (ctxOkStatusMask == 4'h1 || ctxOkStatusMask == 4'hf)
		else $error("done status mask illegal");
endmodule

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire core_clk,
	input wire [15:0] regRdData,
	output reg [11:0] regAddr,
	output reg regWrEn,
	output reg regRdEn,
	output reg [15:0] regWrData
);
	reg tmo;
	initial begin
		{regAddr, regWrEn, regRdEn, regWrData} = 30'h0;
		tmo = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Released lines show the inverse, so a stale value never passes for a real one.
	task wr(input [11:0] a, input [15:0] d);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regWrData <= d;
			regWrEn <= 1'b1;
			@(posedge core_clk);
			regWrEn <= 1'b0;
			regAddr <= ~a;
			regWrData <= ~d;
		end
	endtask
	task rd(input [11:0] a, output [15:0] d);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regRdEn <= 1'b1;
			@(posedge core_clk);
			regRdEn <= 1'b0;
			regAddr <= ~a;
			#1;
			d = regRdData;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task ind(input [15:0] sel, inout [15:0] d);
		integer i;
		reg [15:0] s;
		begin
			if (!sel[14])
				wr(12'h874, d);
			wr(12'h870, sel);
			s = 16'h8000;
			for (i = 0; i < 20 && s[15]; i = i + 1)
				rd(12'h870, s);
			if (s[15])
				tmo = 1'b1;
			if (sel[14])
				rd(12'h874, d);
		end
	endtask
endmodule

// file: tb/tx_dma_channel_context_ram_tb.sv
`timescale 1ns/1ps
module tx_dma_channel_context_ram_tb;
	reg core_clk, rst, dmaRdEn, dmaWrEn, dmaErrEn, dmaRestartEn;
	reg [7:0] dmaRdChan, dmaWrChan, dmaErrChan, dmaRestartChan;
	reg [2:0] dmaRdDword, dmaWrDword;
	reg [1:0] dmaWrHalf;
	reg [31:0] dmaWrData;
	wire [11:0] regAddr;
	wire regWrEn, regRdEn, regRdValid, dmaRdValid, ctxChanActive, ctxNextPtrValid, ctxPriorityBusy;
	wire [15:0] regWrData, regRdData;
	wire [31:0] dmaRdData;
	wire [12:0] ctxByteCount;
	wire [3:0] ctxOkStatusMask;
	integer n_mismatch, num_checks;
	reg [15:0] v;
	tx_dma_channel_context_ram uut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .dmaRdEn(dmaRdEn), .dmaRdChan(dmaRdChan),
		.dmaRdDword(dmaRdDword), .dmaRdData(dmaRdData), .dmaRdValid(dmaRdValid),
		.ctxChanActive(ctxChanActive), .ctxByteCount(ctxByteCount),
		.ctxNextPtrValid(ctxNextPtrValid), .ctxOkStatusMask(ctxOkStatusMask),
		.ctxPriorityBusy(ctxPriorityBusy), .dmaWrEn(dmaWrEn), .dmaWrChan(dmaWrChan),
		.dmaWrDword(dmaWrDword), .dmaWrHalf(dmaWrHalf), .dmaWrData(dmaWrData),
		.dmaErrEn(dmaErrEn), .dmaErrChan(dmaErrChan), .dmaRestartEn(dmaRestartEn),
		.dmaRestartChan(dmaRestartChan));
	host_model h (.core_clk(core_clk), .regRdData(regRdData), .regAddr(regAddr),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input [8*4-1:0] nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task er(input [7:0] c, input [2:0] w);
		begin
			@(posedge core_clk);
			dmaRdEn <= 1'b1;
			dmaRdChan <= c;
			dmaRdDword <= w;
			@(posedge core_clk);
			dmaRdEn <= 1'b0;
			#1;
		end
	endtask
	task ew(input [7:0] c, input [2:0] w, input [31:0] d);
		begin
			@(posedge core_clk);
			{dmaWrEn, dmaWrChan, dmaWrDword, dmaWrHalf, dmaWrData} <= {1'b1, c, w, 2'b11, d};
			@(posedge core_clk);
			dmaWrEn <= 1'b0;
		end
	endtask
	task ev(input e, input [7:0] c);
		begin
			@(posedge core_clk);
			{dmaErrEn, dmaRestartEn, dmaErrChan, dmaRestartChan} <= {!e, e, c, c};
			@(posedge core_clk);
			{dmaErrEn, dmaRestartEn} <= 2'b00;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			h.rd(12'h870, v);
			chk("sel", 32'h0, v);
			h.rd(12'h878, v);
			chk("unmp", 32'h0, v);
		end
	endtask
	// First and last channel, every word code plus one beyond the map.
	task t_map;
		integer c, w;
		reg [31:0] d;
		begin
			for (c = 0; c < 256; c = c + 255)
				for (w = 0; w < 6; w = w + 1)
					ew(c[7:0], w[2:0], {w[2:0], c[7:0], 21'h15a5a5});
			for (c = 0; c < 256; c = c + 255)
				for (w = 0; w < 13; w = w + 1) begin
					d = {w[3:1], c[7:0], 21'h15a5a5};
					d = w[3:1] == 3'd1 ? d & 32'h007ffffb : w[3:1] == 3'd4 ? d & 32'h0000ffff : d;
					v = 16'h0000;
					h.ind({4'b0100, w[3:0], c[7:0]}, v);
					chk("word", w > 11 ? 32'h0 : (d >> (16 * w[0])) & 32'hffff, v);
				end
			er(8'hff, 3'd1);
			chk("edat", 32'h0075a5a1, dmaRdData);
			chk("cnt", 32'h14b4, ctxByteCount);
			chk("pri", 32'h1, ctxPriorityBusy);
			chk("nxt", 32'h1, ctxNextPtrValid);
			chk("mask", 32'h1, ctxOkStatusMask);
		end
	endtask
	task t_host;
		begin
			v = 16'h0006;
			h.ind(16'h02ff, v);
			er(8'hff, 3'd1);
			chk("mask", 32'hf, ctxOkStatusMask);
			chk("act", 32'h0, ctxChanActive);
			v = 16'h1234;
			h.ind(16'h03ff, v);
			h.ind(16'h43ff, v);
			chk("ro", 32'h0075, v);
			h.ind(16'h42ff, v);
			chk("hw", 32'h0002, v);
			v = 16'h0001;
			h.ind(16'h02ff, v);
			ev(1'b0, 8'hff);
			h.ind(16'h42ff, v);
			chk("err", 32'h0000, v);
			h.ind(16'h40ff, v);
			chk("d0", 32'ha5a5, v);
			er(8'hff, 3'd0);
			chk("edw0", 32'h1ff5a5a5, dmaRdData);
			ev(1'b1, 8'hff);
			h.ind(16'h42ff, v);
			chk("rst", 32'h0001, v);
			er(8'hff, 3'd1);
			chk("act", 32'h1, ctxChanActive);
			chk("cnt", 32'h0, ctxByteCount);
			chk("mask", 32'h1, ctxOkStatusMask);
			ew(8'h00, 3'd1, 32'h00020002);
			er(8'h00, 3'd1);
			chk("edat", 32'h00020002, dmaRdData);
			chk("nxt", 32'h0, ctxNextPtrValid);
			chk("pri", 32'h0, ctxPriorityBusy);
			chk("mask", 32'hf, ctxOkStatusMask);
		end
	endtask
	task print_verdict;
		begin
			if (h.tmo)
				n_mismatch = n_mismatch + 1;
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		{dmaRdEn, dmaWrEn, dmaErrEn, dmaRestartEn, dmaRdChan, dmaWrChan, dmaErrChan} = 28'h0;
		{dmaRestartChan, dmaRdDword, dmaWrDword, dmaWrHalf, dmaWrData} = 48'h0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset;
		t_map;
		t_host;
		print_verdict;
	end
endmodule
bind tx_dma_channel_context_ram tx_ctx_properties chk_i (.core_clk(core_clk), .rst(rst),
	.regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
	.dmaRdEn(dmaRdEn), .dmaRdValid(dmaRdValid), .ctxOkStatusMask(ctxOkStatusMask));
